// >>> verilog/prs_defs.svh
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// ==========================================================================
// Register addresses in the special function register space.
`define PRS_ADDR_ACTIVE_PAGE 8'h84
`define PRS_ADDR_SECOND 8'h85
`define PRS_ADDR_BOTTOM 8'h86
`define PRS_ADDR_CONTROL 8'h96

// Page on which the control register lives.
`define PRS_PAGE_CONTROL 8'h0F

// First address of the paged register space and the column width in bits.
`define PRS_SFR_BASE 8'h80
`define PRS_ROW_SHIFT 3

// Page numbers that carry a distinct register set.
`define PRS_PAGE_0 8'h00
`define PRS_PAGE_1 8'h01
`define PRS_PAGE_2 8'h02
`define PRS_PAGE_3 8'h03
`define PRS_PAGE_F 8'h0F

// ==========================================================================
// Reset values.
`define PRS_RST_ACTIVE 8'h00
`define PRS_RST_SECOND 8'h00
`define PRS_RST_BOTTOM 8'h00
`define PRS_RST_CONTROL 8'h01

// ==========================================================================
// Field positions and fixed patterns.
`define PRS_BIT_AUTOPAGE_EN 0
`define PRS_CONTROL_PAD 7'h00
`define PRS_READ_UNMAPPED 8'h00

`endif

// >>> verilog/prs_pkg.sv
package prs_pkg;

  // ========================================================================
  // Byte-wide special function register value.
  typedef logic [7:0] prs_byte_type;

  // Decoded register set selected by an access, one-hot coded.
  typedef enum logic [6:0] {
    PRS_SEL_NONE = 7'h01,
    PRS_SEL_ALL = 7'h02,
    PRS_SEL_P0 = 7'h04,
    PRS_SEL_P1 = 7'h08,
    PRS_SEL_P2 = 7'h10,
    PRS_SEL_P3 = 7'h20,
    PRS_SEL_PF = 7'h40
  } prs_sel_type;

endpackage

// >>> verilog/prs_dec_if.sv
`timescale 1ns/1ps

// ==========================================================================
// Address and page in, decoded selects out.
interface prs_dec_if;
  import prs_pkg::*;
  logic [7:0] addr;
  logic [7:0] page;
  prs_sel_type sel;
  logic [4:0] row;
  logic [2:0] col;
  logic hit_active;
  logic hit_second;
  logic hit_bottom;
  logic hit_control;

  modport decoder (
    input addr,
    input page,
    output sel,
    output row,
    output col,
    output hit_active,
    output hit_second,
    output hit_bottom,
    output hit_control
  );

  modport user (
    output addr,
    output page,
    input sel,
    input row,
    input col,
    input hit_active,
    input hit_second,
    input hit_bottom,
    input hit_control
  );
endinterface

// >>> verilog/prs_sfr_decode.sv
`timescale 1ns/1ps
`include "prs_defs.svh"

module prs_sfr_decode
  import prs_pkg::*;
(
  prs_dec_if.decoder dec
);

  // ========================================================================
  // Addresses that reach the same register whatever page is active.
  function automatic logic is_shared(input logic [7:0] a);
    logic res;
    res = 1'b0;
    if (a[2:0] == 3'h0 && a != 8'h88 && a != 8'h98 && a != 8'hC0 && a != 8'hC8 &&
        a != 8'hD8 && a != 8'hE8 && a != 8'hF8) begin
      res = 1'b1;
    end
    if (a >= 8'h81 && a <= 8'h87) begin
      res = 1'b1;
    end
    if (a == 8'hE6 || a == 8'hE7 || a == 8'hF6 || a == 8'hF7 || a == 8'hFF) begin
      res = 1'b1;
    end
    return res;
  endfunction

  // ========================================================================
  // Row and column split of the paged space.
  // row column decode
  assign dec.row = dec.addr[7:`PRS_ROW_SHIFT];
  assign dec.col = dec.addr[`PRS_ROW_SHIFT-1:0];

  wire in_space = (dec.addr >= `PRS_SFR_BASE);
  wire shared = is_shared(dec.addr);

  // Register set selected by address and active page; undefined pages hit only the shared addresses.
  // page select
  assign dec.sel = !in_space ? PRS_SEL_NONE :
                   shared ? PRS_SEL_ALL :
                   (dec.page == `PRS_PAGE_0) ? PRS_SEL_P0 :
                   (dec.page == `PRS_PAGE_1) ? PRS_SEL_P1 :
                   (dec.page == `PRS_PAGE_2) ? PRS_SEL_P2 :
                   (dec.page == `PRS_PAGE_3) ? PRS_SEL_P3 :
                   (dec.page == `PRS_PAGE_F) ? PRS_SEL_PF : PRS_SEL_NONE;

  // The stack bytes answer on every page.
  // page independent
  assign dec.hit_active = (dec.addr == `PRS_ADDR_ACTIVE_PAGE);
  assign dec.hit_second = (dec.addr == `PRS_ADDR_SECOND);
  assign dec.hit_bottom = (dec.addr == `PRS_ADDR_BOTTOM);
  assign dec.hit_control = (dec.addr == `PRS_ADDR_CONTROL) &&
                           (dec.page == `PRS_PAGE_CONTROL);

endmodule

// >>> verilog/prs_page_stack.sv
// Summary of operation
// - The page context is a three-byte stack: active page on top, second entry, bottom entry.
// - Software reads and writes of a stack byte touch only that byte and never push or pop.
// - Only interrupt service pushes and only interrupt return pops the stack.
// - Writing the second entry sets the page restored at the next interrupt return.
// - Reading the second entry returns the page the next interrupt return will restore.
// - Writing the bottom entry sets what moves into the second entry at the next return.
// - Reading the bottom entry returns its value with no effect on the stack.
// - The second entry sits at address 0x85 on every page and resets to zero.
// - Addresses 0x80 to 0xFF decode in rows of eight, per active page or on all pages.
// - Interrupt entry with autopaging on shifts the stack down and loads the new page.
// - Interrupt return moves second entry to the top and bottom entry to second.
// - Bit 0 of the control register enables autopaging, resets to one, zero disables.
`timescale 1ns/1ps
`include "prs_defs.svh"

module prs_page_stack
  import prs_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_wdata,
  input wire logic int_push,
  input wire logic [7:0] int_page,
  input wire logic int_return,
  output logic [7:0] sfr_rdata,
  output logic sfr_rd_claim,
  output logic [7:0] active_page,
  output logic autopage_enable,
  output prs_sel_type access_sel,
  output logic [4:0] access_row,
  output logic [2:0] access_col
);

  // ========================================================================
  // Stack and control state.
  prs_byte_type active_page_reg;
  prs_byte_type second_entry_reg;
  prs_byte_type bottom_entry_reg;
  logic autopage_enable_reg;
  prs_byte_type rdata_reg;
  logic rd_claim_reg;
  prs_sel_type access_sel_reg;
  logic [4:0] access_row_reg;
  logic [2:0] access_col_reg;

  prs_byte_type active_page_next;
  prs_byte_type second_entry_next;
  prs_byte_type bottom_entry_next;
  logic autopage_enable_next;
  prs_byte_type rdata_next;
  logic rd_claim_next;
  prs_sel_type access_sel_next;
  logic [4:0] access_row_next;
  logic [2:0] access_col_next;

  // Reset pattern of the control byte; only its enable bit is stored.
  localparam prs_byte_type control_rst_value = `PRS_RST_CONTROL;

  // ========================================================================
  // Address decode, evaluated against the current active page.
  prs_dec_if dec ();

  assign dec.addr = sfr_addr;
  assign dec.page = active_page_reg;

  prs_sfr_decode u_decode (
    .dec(dec)
  );

  // ========================================================================
  // Qualified events.
  // A push and a pop in one cycle should not happen; if they do, the push
  // is taken since the core is entering a handler and must see its page.
  wire wr_active = sfr_wr_en && dec.hit_active;
  wire wr_second = sfr_wr_en && dec.hit_second;
  wire wr_bottom = sfr_wr_en && dec.hit_bottom;
  wire wr_control = sfr_wr_en && dec.hit_control;
  wire push_go = int_push && autopage_enable_reg;
  wire pop_go = int_return && autopage_enable_reg && !int_push;
  wire rd_hit = dec.hit_active || dec.hit_second || dec.hit_bottom || dec.hit_control;

  // ========================================================================
  // Next stack contents. Hardware shifts win over a software write in the
  // same cycle so that a handler never starts or ends on a half-moved stack.
  // push shifts down
  assign active_page_next = push_go ? int_page :
                            pop_go ? second_entry_reg :
                            wr_active ? sfr_wdata : active_page_reg;
  assign second_entry_next = push_go ? active_page_reg :
                             pop_go ? bottom_entry_reg :
                             wr_second ? sfr_wdata : second_entry_reg;
  assign bottom_entry_next = push_go ? second_entry_reg :
                             wr_bottom ? sfr_wdata : bottom_entry_reg;
  assign autopage_enable_next = wr_control ? sfr_wdata[`PRS_BIT_AUTOPAGE_EN] :
                                autopage_enable_reg;

  // ========================================================================
  // Read data. Reads return the value before any same-cycle update and
  // leave the stack alone; unmapped addresses read as zero.
  // second entry read
  assign rdata_next = !sfr_rd_en ? rdata_reg :
                      dec.hit_active ? active_page_reg :
                      dec.hit_second ? second_entry_reg :
                      dec.hit_bottom ? bottom_entry_reg :
                      dec.hit_control ? {`PRS_CONTROL_PAD, autopage_enable_reg} :
                      `PRS_READ_UNMAPPED;
  assign rd_claim_next = sfr_rd_en && rd_hit;

  // The decoded set of the last access is held for the peripheral side.
  wire access_any = sfr_rd_en || sfr_wr_en;
  assign access_sel_next = access_any ? dec.sel : access_sel_reg;
  assign access_row_next = access_any ? dec.row : access_row_reg;
  assign access_col_next = access_any ? dec.col : access_col_reg;

  // ========================================================================
  // Stack registers.
  // three byte stack
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_page_reg <= `PRS_RST_ACTIVE;
      second_entry_reg <= `PRS_RST_SECOND;
      bottom_entry_reg <= `PRS_RST_BOTTOM;
      autopage_enable_reg <= control_rst_value[`PRS_BIT_AUTOPAGE_EN];
    end else begin
      active_page_reg <= active_page_next;
      second_entry_reg <= second_entry_next;
      bottom_entry_reg <= bottom_entry_next;
      autopage_enable_reg <= autopage_enable_next;
    end
  end

  // ========================================================================
  // Read and access-select registers.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= `PRS_READ_UNMAPPED;
      rd_claim_reg <= 1'b0;
      access_sel_reg <= PRS_SEL_NONE;
      access_row_reg <= 5'h00;
      access_col_reg <= 3'h0;
    end else begin
      rdata_reg <= rdata_next;
      rd_claim_reg <= rd_claim_next;
      access_sel_reg <= access_sel_next;
      access_row_reg <= access_row_next;
      access_col_reg <= access_col_next;
    end
  end

  // Outputs come straight from the registers.
  assign sfr_rdata = rdata_reg;
  assign sfr_rd_claim = rd_claim_reg;
  assign active_page = active_page_reg;
  assign autopage_enable = autopage_enable_reg;
  assign access_sel = access_sel_reg;
  assign access_row = access_row_reg;
  assign access_col = access_col_reg;

  // ========================================================================
  // Checks on the stack behaviour.
  a_push_loads_page: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    push_go |=> (active_page_reg == $past(int_page)) &&
                (second_entry_reg == $past(active_page_reg)) &&
                (bottom_entry_reg == $past(second_entry_reg))
  ) else $error("Push did not shift the stack down.");

  a_pop_moves_up: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    pop_go |=> (active_page_reg == $past(second_entry_reg)) &&
               (second_entry_reg == $past(bottom_entry_reg))
  ) else $error("Pop did not move the stack up.");

  a_pop_keeps_bottom: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (pop_go && !sfr_wr_en) |=> $stable(bottom_entry_reg)
  ) else $error("Pop changed the bottom entry.");

  a_quiet_stack_stable: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (!int_push && !int_return && !sfr_wr_en) |=>
      $stable(active_page_reg) && $stable(second_entry_reg) && $stable(bottom_entry_reg)
  ) else $error("Stack changed with no event.");

  a_disabled_no_shift: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (!autopage_enable_reg && !sfr_wr_en) |=>
      $stable(active_page_reg) && $stable(second_entry_reg) && $stable(bottom_entry_reg)
  ) else $error("Stack shifted while autopaging was off.");

  a_write_second_only: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (wr_second && !int_push && !int_return) |=>
      (second_entry_reg == $past(sfr_wdata)) && $stable(active_page_reg) &&
      $stable(bottom_entry_reg)
  ) else $error("Second entry write wrong or disturbed the stack.");

  a_write_bottom_only: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (wr_bottom && !int_push && !int_return) |=>
      (bottom_entry_reg == $past(sfr_wdata)) && $stable(active_page_reg) &&
      $stable(second_entry_reg)
  ) else $error("Bottom entry write wrong or disturbed the stack.");

  a_read_second_value: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (sfr_rd_en && dec.hit_second) |=> sfr_rd_claim && (sfr_rdata == $past(second_entry_reg))
  ) else $error("Second entry read returned a wrong value.");

  a_read_bottom_clean: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (sfr_rd_en && dec.hit_bottom && !sfr_wr_en && !int_push && !int_return) |=>
      (sfr_rdata == $past(bottom_entry_reg)) && $stable(bottom_entry_reg) &&
      $stable(second_entry_reg) && $stable(active_page_reg)
  ) else $error("Bottom entry read was wrong or had a side effect.");

  a_second_any_page: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (sfr_addr == `PRS_ADDR_SECOND) |-> dec.hit_second && (dec.sel == PRS_SEL_ALL)
  ) else $error("Second entry did not decode on this page.");

  a_row_decode_space: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (access_any && (sfr_addr >= `PRS_SFR_BASE) &&
     ((active_page_reg <= `PRS_PAGE_3) || (active_page_reg == `PRS_PAGE_F))) |=>
      (access_sel != PRS_SEL_NONE) && (access_row == $past(sfr_addr[7:3]))
  ) else $error("Paged address did not decode to a register set.");

  // ========================================================================
  // Checks on the register port. Reads must never move the stack, since the
  // core may read a stack byte in the middle of a handler, and the control
  // byte must answer on its own page only.
  a_read_no_shift: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (sfr_rd_en && !sfr_wr_en && !int_push && !int_return) |=>
      $stable(active_page_reg) && $stable(second_entry_reg) && $stable(bottom_entry_reg)
  ) else $error("A read moved the stack.");

  a_write_active_only: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (wr_active && !int_push && !int_return) |=>
      (active_page_reg == $past(sfr_wdata)) && $stable(second_entry_reg) &&
      $stable(bottom_entry_reg)
  ) else $error("Active page write wrong or disturbed the stack.");

  a_claim_on_hit: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (sfr_rd_en && rd_hit) |=> sfr_rd_claim
  ) else $error("Read of a stack byte was not claimed.");

  a_unmapped_read_zero: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (sfr_rd_en && !rd_hit) |=>
      !sfr_rd_claim && (sfr_rdata == `PRS_READ_UNMAPPED)
  ) else $error("Unmapped read was claimed or returned data.");

  a_claim_needs_read: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !sfr_rd_en |=> !sfr_rd_claim
  ) else $error("Read claim rose with no read.");

  a_rdata_held: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !sfr_rd_en |=> $stable(sfr_rdata)
  ) else $error("Read data changed with no read.");

  a_control_bit_write: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    wr_control |=>
      (autopage_enable_reg == $past(sfr_wdata[`PRS_BIT_AUTOPAGE_EN]))
  ) else $error("Enable bit did not take the written value.");

  a_control_own_page: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (sfr_wr_en && (sfr_addr == `PRS_ADDR_CONTROL) &&
     (active_page_reg != `PRS_PAGE_CONTROL)) |=> $stable(autopage_enable_reg)
  ) else $error("Control byte answered off its page.");

  a_enable_held: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !wr_control |=> $stable(autopage_enable_reg)
  ) else $error("Enable bit changed with no control write.");

  a_bottom_any_page: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (sfr_addr == `PRS_ADDR_BOTTOM) |-> dec.hit_bottom && (dec.sel == PRS_SEL_ALL)
  ) else $error("Bottom entry did not decode on this page.");

endmodule

// >>> verif/prs_core_model.sv
`timescale 1ns/1ps

// ==========================================================================
// Core side: interrupt vectoring and return sequencing.
module prs_core_model (
  input wire logic core_clk,
  output logic int_push,
  output logic [7:0] int_page,
  output logic int_return
);
  // Quiet at time zero so nothing is pushed while reset is released.
  initial begin
    int_push = 1'b0;
    int_page = 8'h00;
    int_return = 1'b0;
  end

  task automatic push(input logic [7:0] p);
    @(posedge core_clk);
    int_push <= 1'b1;
    int_page <= p;
    @(posedge core_clk);
    int_push <= 1'b0;
    int_page <= ~p; // Stale page is scrambled so the block cannot lean on it.
  endtask

  task automatic pop();
    @(posedge core_clk);
    int_return <= 1'b1;
    @(posedge core_clk);
    int_return <= 1'b0;
  endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
`include "prs_defs.svh"

// ==========================================================================
// Self-checking bench for the page stack.
module tb
  import prs_pkg::*;
;
  logic core_clk;
  logic arst_n;
  logic [7:0] sfr_addr;
  logic sfr_wr_en;
  logic sfr_rd_en;
  logic [7:0] sfr_wdata;
  logic int_push;
  logic [7:0] int_page;
  logic int_return;
  logic [7:0] sfr_rdata;
  logic sfr_rd_claim;
  logic [7:0] active_page;
  logic autopage_enable;
  prs_sel_type access_sel;
  logic [4:0] access_row;
  logic [2:0] access_col;
  int error_cnt;
  int compares;

  prs_page_stack u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata),
    .int_push(int_push), .int_page(int_page), .int_return(int_return),
    .sfr_rdata(sfr_rdata), .sfr_rd_claim(sfr_rd_claim), .active_page(active_page),
    .autopage_enable(autopage_enable), .access_sel(access_sel),
    .access_row(access_row), .access_col(access_col)
  );

  prs_core_model u_core (
    .core_clk(core_clk), .int_push(int_push), .int_page(int_page),
    .int_return(int_return)
  );

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Write is taken at the second edge and visible right after it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_wr_en <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr_en <= 1'b0;
    sfr_wdata <= ~d;
    // Let the taking edge settle so callers see the written value.
    #1;
  endtask

  // Read data and claim stand for the cycle after the taking edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic cl);
    @(posedge core_clk);
    sfr_rd_en <= 1'b1;
    sfr_addr <= a;
    @(posedge core_clk);
    sfr_rd_en <= 1'b0;
    #1;
    chk("read data", exp, sfr_rdata);
    chk("read claim", {7'h00, cl}, {7'h00, sfr_rd_claim});
  endtask

  task automatic stk(input logic [7:0] a, input logic [7:0] s, input logic [7:0] b);
    rd(`PRS_ADDR_ACTIVE_PAGE, a, 1'b1);
    rd(`PRS_ADDR_SECOND, s, 1'b1);
    rd(`PRS_ADDR_BOTTOM, b, 1'b1);
    chk("active page", a, active_page);
  endtask

  task automatic t_reset();
    chk("enable", 8'h01, {7'h00, autopage_enable});
    stk(8'h00, 8'h00, 8'h00);
    wr(`PRS_ADDR_ACTIVE_PAGE, `PRS_PAGE_CONTROL);
    rd(`PRS_ADDR_CONTROL, 8'h01, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_decode();
    logic [7:0] pg [6];
    prs_sel_type sl [6];
    pg = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0F, 8'h07};
    sl = '{PRS_SEL_P0, PRS_SEL_P1, PRS_SEL_P2, PRS_SEL_P3, PRS_SEL_PF, PRS_SEL_NONE};
    for (int i = 0; i < 6; i++) begin
      wr(`PRS_ADDR_ACTIVE_PAGE, pg[i]);
      rd(8'h8B, 8'h00, 1'b0);
      chk("paged select", {1'b0, sl[i]}, {1'b0, access_sel});
      chk("row", 8'h11, {3'h0, access_row});
      chk("column", 8'h03, {5'h00, access_col});
      rd(`PRS_ADDR_SECOND, 8'h00, 1'b1);
      chk("shared select", {1'b0, PRS_SEL_ALL}, {1'b0, access_sel});
    end
    wr(`PRS_ADDR_ACTIVE_PAGE, 8'h00);
    $display("test decode done");
  endtask

  task automatic t_direct();
    wr(`PRS_ADDR_SECOND, 8'hA5);
    wr(`PRS_ADDR_BOTTOM, 8'h3C);
    stk(8'h00, 8'hA5, 8'h3C);
    stk(8'h00, 8'hA5, 8'h3C);
    $display("test direct done");
  endtask

  task automatic t_stack();
    wr(`PRS_ADDR_ACTIVE_PAGE, 8'h0F);
    wr(`PRS_ADDR_SECOND, 8'h11);
    wr(`PRS_ADDR_BOTTOM, 8'h22);
    u_core.push(8'h02);
    stk(8'h02, 8'h0F, 8'h11);
    u_core.push(8'h00);
    stk(8'h00, 8'h02, 8'h0F);
    wr(`PRS_ADDR_SECOND, 8'h03);
    u_core.pop();
    stk(8'h03, 8'h0F, 8'h0F);
    u_core.push(8'h05);
    u_core.pop();
    stk(8'h03, 8'h0F, 8'h0F);
    $display("test stack done");
  endtask

  task automatic t_disable();
    wr(`PRS_ADDR_ACTIVE_PAGE, 8'h0F);
    wr(`PRS_ADDR_SECOND, 8'h44);
    wr(`PRS_ADDR_CONTROL, 8'h00);
    chk("enable", 8'h00, {7'h00, autopage_enable});
    u_core.push(8'h01);
    u_core.pop();
    stk(8'h0F, 8'h44, 8'h0F);
    rd(`PRS_ADDR_CONTROL, 8'h00, 1'b1);
    wr(`PRS_ADDR_CONTROL, 8'h01);
    chk("enable", 8'h01, {7'h00, autopage_enable});
    wr(`PRS_ADDR_ACTIVE_PAGE, `PRS_PAGE_0);
    wr(`PRS_ADDR_CONTROL, 8'h00);
    chk("enable off page", 8'h01, {7'h00, autopage_enable});
    rd(`PRS_ADDR_CONTROL, `PRS_READ_UNMAPPED, 1'b0);
    $display("test disable done");
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard; no wait in this bench should come near it.
  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end

  // Main sequence: inputs quiet at time zero, ten cycles of reset.
  initial begin
    error_cnt = 0;
    compares = 0;
    arst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr_en = 1'b0;
    sfr_rd_en = 1'b0;
    sfr_wdata = 8'h00;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_decode();
    t_direct();
    t_stack();
    t_disable();
    final_report();
  end
endmodule
